// ### verilog/jog_ctrl_defines.vh
`ifndef JOG_CTRL_DEFINES_VH
`define JOG_CTRL_DEFINES_VH

// Register byte offsets
`define OFF_CMD_MODE      12'h000
`define OFF_JOG_CTRL      12'h004
`define OFF_JOG_ACCEL     12'h008
`define OFF_JOG_DECEL     12'h00c
`define OFF_SECOND_SPEED  12'h010
`define OFF_JOG_MODE      12'h014
`define OFF_LIMIT_DEF     12'h018
`define OFF_VEL_SEL       12'h01c
`define OFF_VEL_VAL       12'h020
`define OFF_STATUS        12'h024
`define OFF_POS_ERR       12'h048
`define OFF_SPEED_OUT     12'h028
`define OFF_DRIVE_CFG     12'h02c
`define POS_ERR_INDEX     8'd72

// Jog control register bits (write 1 acts)
`define CTRL_JOG_ENABLE   0
`define CTRL_JOG_DISABLE  1
`define CTRL_WAIT_START   2
`define CTRL_WAIT_DONE    3

// Status bits
`define ST_JOG_ARMED      0
`define ST_WAITING        1
`define ST_JOGGING        2
`define ST_POS_FAULT      3
`define ST_REJECT         4

// Rates in units of 0.167 rps/s: 1 .. 32701
`define ACC_MIN           16'd1
`define ACC_MAX           16'd32701
`define ACC_RST           16'd600
`define CMD_MODE_RST      8'h15
// Speed in units of 0.0042 rps: 1 .. 31746 (fast) or 19047 (integrated)
`define SPD_MIN           16'd1
`define SPD_MAX_FAST      16'd31746
`define SPD_MAX_SLOW      16'd19047
`define SPD_RST           16'd2381
`define VEL8_MIN          8'd1
`define VEL8_MAX          8'd136
`define VEL8_RST          8'd10

`define JOG_MODE_POS      2'd1
`define JOG_MODE_VEL      2'd2
`define LIM_NONE          2'd0
`define LIM_DEF1          2'd1
`define LIM_DEF2          2'd2

`define OWN_JOG           2'd1
`define OWN_LIMIT         2'd2

`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// ### verilog/jog_motion_control.v
// Functional notes
// - Position error readable, index 072 register
// - Accel read returns stored rate unchanged
// - Accel write sets accel and decel
// - Accel change refused while jogging
// - Accel range 0.167 to 5461.067 rps/s
// - Second speed only in modes 13,14,17,18
// - Speed select input picks second speed
// - Second speed limits per drive size
// - Eight velocities, index 1-8, 1-136 rps
// - Jog disable stops jog inputs moving motor
// - Jog inputs move cw/ccw during wait
// - Jog enable ignored in owning command modes
// - Limit define 1/2 takes inputs, jog off
// - Last of jog/limit wins; mode dominates
// - Wait condition met ends jogging
// - Decel range checked, frozen while jogging
// - Position jog faults on excess error
// - Velocity jog ignores fault, velocity gains
// - Stepper ignores jog mode 2
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`include "jog_ctrl_defines.vh"
module jog_motion_control
(
  input wire clk,
  input wire arst_n,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] cmd_position,
  input wire [31:0] enc_position,
  input wire [31:0] position_fault_limit,
  input wire jog_cw_in,
  input wire jog_ccw_in,
  input wire speed_select_input,
  input wire [15:0] primary_speed,
  output reg jog_cw_ff,
  output reg jog_ccw_ff,
  output reg vel_loop_gains_ff,
  output reg pos_fault_ff,
  output reg limits_active_ff
);

  // ****************************************
  // Functions
  // ****************************************
  function mode_owns_inputs;
    input [7:0] m;
    begin
      mode_owns_inputs = (m == 8'd7) || (m >= 8'd11 && m <= 8'd18);
    end
  endfunction

  function in_range16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range16 = (v >= lo) && (v <= hi);
    end
  endfunction

  // Oscillator modes that honour the second speed
  function osc_mode_sel;
    input [7:0] m;
    begin
      osc_mode_sel = (m == 8'd13) || (m == 8'd14) || (m == 8'd17) || (m == 8'd18);
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] cmd_mode_ff;
  // Rates and speeds are kept in their quantised units
  reg [15:0] accel_ff;
  reg [15:0] decel_ff;
  reg [15:0] second_speed_ff;
  reg [1:0] jog_mode_ff;
  reg [1:0] limit_def_ff;
  reg [1:0] owner_ff;
  reg waiting_ff;
  reg reject_ff;
  reg is_stepper_ff;
  reg slow_drive_ff;
  reg [2:0] vel_sel_ff;
  reg [7:0] vel_tab_ff [0:7];
  reg [31:0] pos_err_ff;
  reg [15:0] speed_out_ff;

  reg aw_hold_ff;
  reg w_hold_ff;
  reg [11:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  // ****************************************
  // Jog input ownership
  // ****************************************
  // Ownership survives a spell in an owning command mode,
  // so returning to a free mode restores the last user
  wire jogging = jog_cw_ff | jog_ccw_ff;
  wire jog_armed = (owner_ff == `OWN_JOG) && !mode_owns_inputs(cmd_mode_ff);
  wire [31:0] pos_err = cmd_position - enc_position;
  wire [15:0] spd_max = slow_drive_ff ? `SPD_MAX_SLOW : `SPD_MAX_FAST;
  wire osc_mode = osc_mode_sel(cmd_mode_ff);

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  // Writes are applied one at a time in arrival order
  // Address and data may come in either order; each is parked until its partner arrives
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  wire [11:0] wa = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wd = w_hold_ff ? wdata_ff : s_axi_wdata;
  wire [3:0] ws = w_hold_ff ? wstrb_ff : s_axi_wstrb;
  wire have_aw = aw_hold_ff || (s_axi_awvalid && s_axi_awready);
  wire have_w = w_hold_ff || (s_axi_wvalid && s_axi_wready);
  wire do_wr = have_aw && have_w && !bvalid_ff;
  wire full_word = (ws == 4'hf);

  integer i;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
      cmd_mode_ff <= `CMD_MODE_RST;
      accel_ff <= `ACC_RST;
      decel_ff <= `ACC_RST;
      second_speed_ff <= `SPD_RST;
      jog_mode_ff <= `JOG_MODE_POS;
      limit_def_ff <= `LIM_NONE;
      owner_ff <= 2'd0;
      waiting_ff <= 1'b0;
      reject_ff <= 1'b0;
      is_stepper_ff <= 1'b0;
      slow_drive_ff <= 1'b0;
      vel_sel_ff <= 3'd0;
      for (i = 0; i < 8; i = i + 1)
        vel_tab_ff[i] <= `VEL8_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready && !do_wr)
      begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr)
      begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
      if (do_wr)
      begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= `RESP_OKAY;
        // A refused write changes no setting; only accel, decel and second-speed refusals set reject_ff
        // Partial strobes would split a fixed-point value, so refuse them
        if (!full_word)
          bresp_ff <= `RESP_SLVERR;
        else
          case (wa)
            `OFF_CMD_MODE: cmd_mode_ff <= wd[7:0];
            `OFF_JOG_CTRL:
            begin
              if (wd[`CTRL_JOG_ENABLE] && !mode_owns_inputs(cmd_mode_ff))
                owner_ff <= `OWN_JOG;
              if (wd[`CTRL_JOG_DISABLE] && owner_ff == `OWN_JOG)
                owner_ff <= 2'd0;
              if (wd[`CTRL_WAIT_START])
                waiting_ff <= 1'b1;
              if (wd[`CTRL_WAIT_DONE])
                waiting_ff <= 1'b0;
            end
            `OFF_JOG_ACCEL:
            begin
              if (jogging || !in_range16(wd[15:0], `ACC_MIN, `ACC_MAX))
              begin
                bresp_ff <= `RESP_SLVERR;
                reject_ff <= 1'b1;
              end
              else
              begin
                accel_ff <= wd[15:0];
                decel_ff <= wd[15:0];
              end
            end
            `OFF_JOG_DECEL:
            begin
              if (jogging || !in_range16(wd[15:0], `ACC_MIN, `ACC_MAX))
              begin
                bresp_ff <= `RESP_SLVERR;
                reject_ff <= 1'b1;
              end
              else
                decel_ff <= wd[15:0];
            end
            `OFF_SECOND_SPEED:
            begin
              if (!in_range16(wd[15:0], `SPD_MIN, spd_max))
              begin
                bresp_ff <= `RESP_SLVERR;
                reject_ff <= 1'b1;
              end
              else
                second_speed_ff <= wd[15:0];
            end
            `OFF_JOG_MODE:
            begin
              // A stepper keeps position-type; a velocity request is dropped quietly
              if (wd[1:0] == `JOG_MODE_POS || (wd[1:0] == `JOG_MODE_VEL && !is_stepper_ff))
                jog_mode_ff <= wd[1:0];
            end
            `OFF_LIMIT_DEF:
            begin
              limit_def_ff <= wd[1:0];
              if ((wd[1:0] == `LIM_DEF1 || wd[1:0] == `LIM_DEF2) && !mode_owns_inputs(cmd_mode_ff))
                owner_ff <= `OWN_LIMIT;
            end
            `OFF_VEL_SEL:
            begin
              // Index is stored zero-based and read back one-based
              if (wd[31:4] == 28'h0 && wd[3:0] >= 4'd1 && wd[3:0] <= 4'd8)
                vel_sel_ff <= wd[2:0] - 3'd1;
              else
                bresp_ff <= `RESP_SLVERR;
            end
            `OFF_VEL_VAL:
            begin
              if (wd[7:0] >= `VEL8_MIN && wd[7:0] <= `VEL8_MAX && wd[31:8] == 24'h0)
                vel_tab_ff[vel_sel_ff] <= wd[7:0];
              else
                bresp_ff <= `RESP_SLVERR;
            end
            `OFF_STATUS:
              if (wd[`ST_REJECT])
                reject_ff <= 1'b0;
            `OFF_DRIVE_CFG:
            begin
              is_stepper_ff <= wd[0];
              slow_drive_ff <= wd[1];
              if (wd[0])
                jog_mode_ff <= `JOG_MODE_POS;
            end
            default: bresp_ff <= `RESP_SLVERR;
          endcase
      end
    end
  end

  // ****************************************
  // Jog outputs and motion status
  // ****************************************
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      jog_cw_ff <= 1'b0;
      jog_ccw_ff <= 1'b0;
      vel_loop_gains_ff <= 1'b0;
      pos_fault_ff <= 1'b0;
      limits_active_ff <= 1'b0;
      pos_err_ff <= 32'h0000_0000;
      speed_out_ff <= 16'h0000;
    end
    else
    begin
      pos_err_ff <= pos_err;
      // Opposite requests cancel rather than pick a winner
      jog_cw_ff <= jog_armed && waiting_ff && jog_cw_in && !jog_ccw_in;
      jog_ccw_ff <= jog_armed && waiting_ff && jog_ccw_in && !jog_cw_in;
      vel_loop_gains_ff <= (jog_mode_ff == `JOG_MODE_VEL) && jogging;
      limits_active_ff <= (owner_ff == `OWN_LIMIT) && !mode_owns_inputs(cmd_mode_ff);
      // Fault is sticky until reset
      if (jogging && jog_mode_ff == `JOG_MODE_POS)
      begin
        // Magnitude test; a limit at the most negative value is not supported
        if ($signed(pos_err) > $signed(position_fault_limit) ||
            $signed(pos_err) < -$signed(position_fault_limit))
          pos_fault_ff <= 1'b1;
      end
      // Primary speed passes through outside the oscillator modes
      if (osc_mode && speed_select_input)
        speed_out_ff <= second_speed_ff;
      else
        speed_out_ff <= primary_speed;
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  // Position error is a registered copy, so its read never waits on the loop
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `RESP_OKAY;
    end
    else
    begin
      if (rvalid_ff && s_axi_rready)
        rvalid_ff <= 1'b0;
      if (s_axi_arvalid && !rvalid_ff)
      begin
        rvalid_ff <= 1'b1;
        rresp_ff <= `RESP_OKAY;
        rdata_ff <= 32'h0000_0000;
        case (s_axi_araddr)
          `OFF_CMD_MODE: rdata_ff <= {24'h0, cmd_mode_ff};
          `OFF_JOG_ACCEL: rdata_ff <= {16'h0, accel_ff};
          `OFF_JOG_DECEL: rdata_ff <= {16'h0, decel_ff};
          `OFF_SECOND_SPEED: rdata_ff <= {16'h0, second_speed_ff};
          `OFF_JOG_MODE: rdata_ff <= {30'h0, jog_mode_ff};
          `OFF_LIMIT_DEF: rdata_ff <= {30'h0, limit_def_ff};
          `OFF_VEL_SEL: rdata_ff <= {28'h0, 1'b0, vel_sel_ff} + 32'h1;
          `OFF_VEL_VAL: rdata_ff <= {24'h0, vel_tab_ff[vel_sel_ff]};
          `OFF_STATUS: rdata_ff <= {27'h0, reject_ff, pos_fault_ff, jogging, waiting_ff, jog_armed};
          `OFF_POS_ERR: rdata_ff <= pos_err_ff;
          `OFF_SPEED_OUT: rdata_ff <= {16'h0, speed_out_ff};
          `OFF_DRIVE_CFG: rdata_ff <= {30'h0, slow_drive_ff, is_stepper_ff};
          `OFF_JOG_CTRL: rdata_ff <= 32'h0000_0000;
          default: rresp_ff <= `RESP_SLVERR;
        endcase
      end
    end
  end

endmodule

// ### sim/jog_motion_control_properties.sv
module jmc_props
(
  input wire clk,
  input wire arst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire jog_cw_in,
  input wire jog_ccw_in,
  input wire jog_cw_ff,
  input wire jog_ccw_ff,
  input wire pos_fault_ff,
  input wire limits_active_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ********************
  // Bus and jog checks
  // ********************
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_cw_cause: assert property (jog_cw_ff |-> $past(jog_cw_in) && !$past(jog_ccw_in))
    else $error("cw drive without cw input");
  a_ccw_cause: assert property (jog_ccw_ff |-> $past(jog_ccw_in) && !$past(jog_cw_in))
    else $error("ccw drive without ccw input");
  a_limit_no_jog: assert property (limits_active_ff |-> !jog_cw_ff && !jog_ccw_ff)
    else $error("jog drive while inputs are limits");
  a_fault_sticky: assert property (pos_fault_ff |=> pos_fault_ff)
    else $error("fault cleared without reset");
  c_jog: cover property (jog_cw_ff);
  c_limit: cover property (limits_active_ff);
  c_fault: cover property (pos_fault_ff);
endmodule

bind jog_motion_control jmc_props u_props
(
  .clk(clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .jog_cw_in(jog_cw_in), .jog_ccw_in(jog_ccw_in), .jog_cw_ff(jog_cw_ff),
  .jog_ccw_ff(jog_ccw_ff), .pos_fault_ff(pos_fault_ff), .limits_active_ff(limits_active_ff)
);

// ### sim/axil_host.sv
module axil_host
(
  input wire clk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Host command channel
  // ********************
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Address and data released each on its own handshake
  task automatic wr(input [11:0] a, input [31:0] d, output [1:0] r);
    logic pa, pw;
    // Start after an edge so back-to-back calls never drive a signal twice at once
    @(posedge clk);
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw)
    begin
      @(posedge clk);
      if (pa && awready) awvalid <= 1'b0;
      if (pw && wready) wvalid <= 1'b0;
      pa = pa && !awready;
      pw = pw && !wready;
    end
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input [11:0] a, output [31:0] d, output [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// ### sim/jog_motion_control_tb.sv
`include "jog_ctrl_defines.vh"
module jog_motion_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, cw_in, ccw_in, sel, cw, ccw, vg, flt, lim;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, cmd_pos, enc_pos, flim, d;
  logic [1:0] bresp, rresp, r;
  logic [15:0] prim;
  logic [3:0] strb;
  int err_count, n_compared;
  int modes[10] = '{7, 11, 12, 13, 14, 15, 16, 17, 18, 7};
  axil_host u_host
  (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );
  jog_motion_control u_dut
  (
    .clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmd_position(cmd_pos),
    .enc_position(enc_pos), .position_fault_limit(flim), .jog_cw_in(cw_in), .jog_ccw_in(ccw_in),
    .speed_select_input(sel), .primary_speed(prim), .jog_cw_ff(cw), .jog_ccw_ff(ccw),
    .vel_loop_gains_ff(vg), .pos_fault_ff(flt), .limits_active_ff(lim)
  );
  // ********************
  // Helpers
  // ********************
  task automatic chk(input string n, input [31:0] e, input [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input [11:0] a, input [31:0] e);
    u_host.rd(a, d, r);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic wc(input [11:0] a, input [31:0] v, input [1:0] e = `RESP_OKAY);
    u_host.wr(a, v, r);
    chk($sformatf("bresp %h", a), {30'h0, e}, {30'h0, r});
  endtask
  task automatic w3;
    repeat (3) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_reset;
    rc(`OFF_JOG_ACCEL, `ACC_RST);
    rc(`OFF_JOG_MODE, `JOG_MODE_POS);
    rc(`OFF_POS_ERR, 32'ha);
  endtask
  task automatic t_ranges;
    wc(`OFF_JOG_ACCEL, 32'h64);
    rc(`OFF_JOG_DECEL, 32'h64);
    wc(`OFF_JOG_DECEL, 32'h19);
    rc(`OFF_JOG_ACCEL, 32'h64);
    wc(`OFF_JOG_ACCEL, 32'h0, `RESP_SLVERR);
    wc(`OFF_JOG_ACCEL, 32'h7fbd);
    wc(`OFF_JOG_DECEL, 32'h7fbe, `RESP_SLVERR);
    strb <= 4'h3;
    wc(`OFF_JOG_DECEL, 32'h20, `RESP_SLVERR);
    strb <= 4'hf;
    rc(`OFF_JOG_DECEL, 32'h7fbd);
    wc(`OFF_SECOND_SPEED, 32'h7c03, `RESP_SLVERR);
    wc(`OFF_VEL_SEL, 32'h9, `RESP_SLVERR);
    wc(`OFF_VEL_VAL, 32'h88);
    wc(`OFF_VEL_VAL, 32'h89, `RESP_SLVERR);
    rc(`OFF_VEL_VAL, 32'h88);
    wc(`OFF_VEL_SEL, 32'h8);
    rc(`OFF_VEL_SEL, 32'h8);
    rc(`OFF_VEL_VAL, `VEL8_RST);
    wc(12'h3fc, 32'h1, `RESP_SLVERR);
  endtask
  task automatic t_jog;
    wc(`OFF_JOG_CTRL, 32'h1);
    wc(`OFF_JOG_CTRL, 32'h4);
    ccw_in <= 1'b1;
    w3;
    chk("jog_ccw", 1, ccw);
    ccw_in <= 1'b0;
    cw_in <= 1'b1;
    w3;
    chk("jog_cw", 1, cw);
    wc(`OFF_JOG_ACCEL, 32'h5, `RESP_SLVERR);
    wc(`OFF_JOG_DECEL, 32'h5, `RESP_SLVERR);
    wc(`OFF_JOG_CTRL, 32'h8);
    w3;
    chk("jog_cw", 0, cw);
    wc(`OFF_JOG_CTRL, 32'h6);
    w3;
    chk("jog_cw", 0, cw);
    wc(`OFF_JOG_CTRL, 32'h8);
  endtask
  task automatic t_limit;
    wc(`OFF_JOG_CTRL, 32'h1);
    wc(`OFF_LIMIT_DEF, 32'h1);
    wc(`OFF_JOG_CTRL, 32'h4);
    w3;
    chk("limits", 1, lim);
    chk("jog_cw", 0, cw);
    wc(`OFF_JOG_CTRL, 32'h1);
    w3;
    chk("jog_cw", 1, cw);
    wc(`OFF_LIMIT_DEF, 32'h2);
    w3;
    chk("jog_cw", 0, cw);
    wc(`OFF_JOG_CTRL, 32'ha);
  endtask
  task automatic t_modes;
    sel <= 1'b1;
    foreach (modes[i])
    begin
      wc(`OFF_JOG_CTRL, 32'h1);
      wc(`OFF_CMD_MODE, modes[i]);
      wc(`OFF_JOG_CTRL, 32'h4);
      w3;
      chk("jog_cw", 0, cw);
      rc(`OFF_SPEED_OUT, modes[i] inside {13, 14, 17, 18} ? `SPD_RST : prim);
      wc(`OFF_JOG_CTRL, 32'h2);
      wc(`OFF_JOG_CTRL, 32'h1);
      wc(`OFF_CMD_MODE, 32'h15);
      w3;
      chk("jog_cw", 0, cw);
      wc(`OFF_JOG_CTRL, 32'ha);
    end
    sel <= 1'b0;
    wc(`OFF_CMD_MODE, 32'hd);
    rc(`OFF_SPEED_OUT, prim);
    wc(`OFF_CMD_MODE, 32'h15);
  endtask
  task automatic t_fault;
    wc(`OFF_DRIVE_CFG, 32'h1);
    wc(`OFF_JOG_MODE, 32'h2);
    rc(`OFF_JOG_MODE, 32'h1);
    wc(`OFF_DRIVE_CFG, 32'h0);
    wc(`OFF_JOG_MODE, 32'h2);
    rc(`OFF_JOG_MODE, 32'h2);
    wc(`OFF_JOG_CTRL, 32'h1);
    wc(`OFF_JOG_CTRL, 32'h4);
    flim <= 32'h5;
    w3;
    chk("vel_gains", 1, vg);
    chk("pos_fault", 0, flt);
    wc(`OFF_JOG_MODE, 32'h1);
    w3;
    chk("pos_fault", 1, flt);
    wc(`OFF_SECOND_SPEED, 32'h7c02);
    wc(`OFF_DRIVE_CFG, 32'h2);
    wc(`OFF_SECOND_SPEED, 32'h4a68, `RESP_SLVERR);
    wc(`OFF_SECOND_SPEED, 32'h4a67);
    rc(`OFF_SECOND_SPEED, 32'h4a67);
    rc(`OFF_STATUS, 32'h1f);
    wc(`OFF_STATUS, 32'h10);
    rc(`OFF_STATUS, 32'hf);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200us;
    err_count++;
    tally_and_finish;
  end
  initial
  begin
    {arst_n, cw_in, ccw_in, sel} = '0;
    cmd_pos = 32'h32;
    enc_pos = 32'h28;
    flim = 32'h3e8;
    prim = 16'h100;
    strb = 4'hf;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_ranges;
    t_jog;
    t_limit;
    t_modes;
    t_fault;
    tally_and_finish;
  end
endmodule
